// >>> design/sfr_upper_pkg.sv
package sfr_upper_pkg;
	localparam int IDX_W = 9;
	localparam int PC_W = 13;
	// Register indices; byte address is four times the index
	localparam logic [8:0] IDX_IND_B2   = 9'h100;
	localparam logic [8:0] IDX_TIMER_ZERO_COUNT     = 9'h101;
	localparam logic [8:0] IDX_PCL_B2   = 9'h102;
	localparam logic [8:0] IDX_ALU_B2   = 9'h103;
	localparam logic [8:0] IDX_PTR_B2   = 9'h104;
	localparam logic [8:0] IDX_PB_PINS  = 9'h106;
	localparam logic [8:0] IDX_PCH_B2   = 9'h10a;
	localparam logic [8:0] IDX_IRQ_B2   = 9'h10b;
	localparam logic [8:0] IDX_NVD_LO   = 9'h10c;
	localparam logic [8:0] IDX_NVA_LO   = 9'h10d;
	localparam logic [8:0] IDX_NVD_HI   = 9'h10e;
	localparam logic [8:0] IDX_NVA_HI   = 9'h10f;
	localparam logic [8:0] IDX_IND_B3   = 9'h180;
	localparam logic [8:0] IDX_OPTION   = 9'h181;
	localparam logic [8:0] IDX_PCL_B3   = 9'h182;
	localparam logic [8:0] IDX_ALU_B3   = 9'h183;
	localparam logic [8:0] IDX_PTR_B3   = 9'h184;
	localparam logic [8:0] IDX_PB_DIR   = 9'h186;
	localparam logic [8:0] IDX_PCH_B3   = 9'h18a;
	localparam logic [8:0] IDX_IRQ_B3   = 9'h18b;
	localparam logic [8:0] IDX_NV_CTRL  = 9'h18c;
	localparam logic [8:0] IDX_UNLOCK   = 9'h18d;
	localparam logic [8:0] IDX_RSV_A    = 9'h18e;
	localparam logic [8:0] IDX_RSV_B    = 9'h18f;
	localparam logic [7:0] RST_ZERO     = 8'h00;
	localparam logic [7:0] RST_ONES     = 8'hff;
	localparam logic [7:0] RST_ALU_POR  = 8'h18;
	localparam logic [7:0] MASK_PCH     = 8'h1f;
	localparam logic [7:0] MASK_NVD_HI  = 8'h3f;
	localparam logic [7:0] MASK_NVA_HI  = 8'h1f;
	localparam logic [7:0] MASK_NV_CTRL = 8'h8f;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	typedef struct packed {
		logic       irp;
		logic [1:0] bank_sel;
		logic       not_timeout;
		logic       not_powerdown;
		logic       zero;
		logic       digit_carry;
		logic       carry;
	} alu_flags_t;
	typedef struct packed {
		logic gie;
		logic peie;
		logic t0ie;
		logic inte;
		logic rbie;
		logic t0if;
		logic intf;
		logic rbif;
	} irq_ctrl_t;
	typedef struct packed {
		logic       prog_space;
		logic [2:0] unused;
		logic       wr_err;
		logic       wr_en;
		logic       wr_go;
		logic       rd_go;
	} nv_ctrl_t;
	typedef struct packed {
		logic       valid;
		logic       we;
		logic [8:0] addr;
		logic [7:0] wdata;
	} dm_req_t;
	typedef enum logic [4:0] {
		SEL_NONE, SEL_IND, SEL_TIMER_ZERO_COUNT, SEL_PCL, SEL_ALU, SEL_PTR, SEL_PB, SEL_PCH,
		SEL_IRQ, SEL_NVD, SEL_NVA, SEL_NVDH, SEL_NVAH, SEL_OPT, SEL_DIR, SEL_NVC,
		SEL_UNLOCK, SEL_RSVA, SEL_RSVB
	} sel_t;
	typedef enum logic [4:0] {
		ST_IDLE   = 5'h01,
		ST_MEM_WR = 5'h02,
		ST_MEM_RD = 5'h04,
		ST_BRESP  = 5'h08,
		ST_RRESP  = 5'h10
	} state_t;
endpackage : sfr_upper_pkg

// >>> design/sfr_upper_banks.sv
// Functional notes
// - Upper program counter has no address; reached only through the high latch.
// - High latch holds PC bits 12:8, all copied in on a low-byte write; a branch copies only its bits 4:3.
// - High latch has five bits, upper three read zero, zero after any reset.
// - Core registers decode at same offset in every bank, one physical copy.
// - Unimplemented addresses and bits read zero; writes to them do nothing.
// - Fourth and fifth port registers absent on small variant, read zero.
// - External pin and watchdog resets apply a second set of reset values.
// - Undefined bits reset to zero; u bits hold; q bits follow reset cause.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
module sfr_upper_banks #(
	parameter int ADDR_W = 11
) (
	input  wire logic                     MCLK,
	input  wire logic                     RESET_N,
	input  wire logic                     EXT_RESET_PIN_N,
	input  wire logic                     WDT_TIMEOUT,
	input  wire logic [ADDR_W-1:0]        AWADDR,
	input  wire logic                     AWVALID,
	output      logic                     AWREADY,
	input  wire logic [31:0]              WDATA,
	input  wire logic [3:0]               WSTRB,
	input  wire logic                     WVALID,
	output      logic                     WREADY,
	output      logic [1:0]               BRESP,
	output      logic                     BVALID,
	input  wire logic                     BREADY,
	input  wire logic [ADDR_W-1:0]        ARADDR,
	input  wire logic                     ARVALID,
	output      logic                     ARREADY,
	output      logic [31:0]              RDATA,
	output      logic [1:0]               RRESP,
	output      logic                     RVALID,
	input  wire logic                     RREADY,
	input  wire logic                     PC_ADVANCE,
	input  wire logic                     BRANCH_TAKE,
	input  wire logic [10:0]              BRANCH_TARGET,
	input  wire logic                     ALU_FLAG_UPDATE,
	input  wire logic [2:0]               ALU_FLAG_VALUE,
	input  wire logic                     SLEEP_ENTER,
	input  wire logic                     WDT_CLEAR,
	input  wire logic [2:0]               IRQ_EVENTS,
	input  wire logic                     NV_DONE,
	input  wire logic [7:0]               SECOND_PORT_PINS_PINS,
	input  wire logic [7:0]               DM_RDATA,
	input  wire logic                     DM_ACK,
	output      sfr_upper_pkg::dm_req_t   DM_REQ,
	output      logic [12:0]              PC_VALUE,
	output      sfr_upper_pkg::alu_flags_t ALU_FLAGS,
	output      sfr_upper_pkg::irq_ctrl_t IRQ_CONTROL,
	output      sfr_upper_pkg::nv_ctrl_t  NV_CONTROL,
	output      logic [15:0]              NV_ADDR,
	output      logic [15:0]              NV_DATA,
	output      logic                     NV_UNLOCK_STROBE,
	output      logic [7:0]               NV_UNLOCK_DATA,
	output      logic [7:0]               OPTION_BITS,
	output      logic [7:0]               TIMER_ZERO,
	output      logic [7:0]               SECOND_PORT_PINS_LATCH,
	output      logic [7:0]               SECOND_PORT_PINS_DIR
);
	if (ADDR_W < sfr_upper_pkg::IDX_W + 2)
	begin : g_chk
		$error("ADDR_W too small for the register map");
	end

	sfr_upper_pkg::state_t     st_reg;
	sfr_upper_pkg::alu_flags_t alu_reg;
	sfr_upper_pkg::irq_ctrl_t  irq_reg;
	sfr_upper_pkg::irq_ctrl_t  irq_next;
	sfr_upper_pkg::nv_ctrl_t   nvc_reg;
	sfr_upper_pkg::dm_req_t    dm_reg;
	sfr_upper_pkg::sel_t       wsel;
	sfr_upper_pkg::sel_t       rsel;
	logic [8:0]  aw_idx_reg;
	logic [8:0]  ar_idx_reg;
	logic [7:0]  wdata_reg;
	logic        wstrb_reg;
	logic        aw_full_reg;
	logic        w_full_reg;
	logic        ar_full_reg;
	logic [31:0] rdata_reg;
	logic [7:0]  rbyte;
	logic        wr_go;
	logic        rd_go;
	logic        reg_wr;
	logic [1:0]  ext_sync_reg;
	logic [1:0]  wdt_sync_reg;
	logic [7:0]  pins_s1_reg;
	logic [7:0]  pins_s2_reg;
	logic        other_rst;
	logic [12:0] pc_reg;
	logic [4:0]  pch_reg;
	logic [7:0]  timer_zero_count_reg;
	logic [7:0]  ptr_reg;
	logic [7:0]  latch_reg;
	logic [7:0]  nvd_reg;
	logic [7:0]  nva_reg;
	logic [7:0]  nvdh_reg;
	logic [7:0]  nvah_reg;
	logic [7:0]  opt_reg;
	logic [7:0]  dir_reg;
	logic [7:0]  rsva_reg;
	logic [7:0]  rsvb_reg;
	logic        unl_stb_reg;
	logic [7:0]  unl_dat_reg;

	// Core registers mirror on the low seven bits, others decode exactly
	function automatic sfr_upper_pkg::sel_t decode(input logic [8:0] idx);
		sfr_upper_pkg::sel_t s;
		s = sfr_upper_pkg::SEL_NONE;
		case (idx[6:0])
			sfr_upper_pkg::IDX_IND_B2[6:0]: s = sfr_upper_pkg::SEL_IND;
			sfr_upper_pkg::IDX_PCL_B2[6:0]: s = sfr_upper_pkg::SEL_PCL;
			sfr_upper_pkg::IDX_ALU_B2[6:0]: s = sfr_upper_pkg::SEL_ALU;
			sfr_upper_pkg::IDX_PTR_B2[6:0]: s = sfr_upper_pkg::SEL_PTR;
			sfr_upper_pkg::IDX_PCH_B2[6:0]: s = sfr_upper_pkg::SEL_PCH;
			sfr_upper_pkg::IDX_IRQ_B2[6:0]: s = sfr_upper_pkg::SEL_IRQ;
			default:
			begin
				case (idx)
					sfr_upper_pkg::IDX_TIMER_ZERO_COUNT:    s = sfr_upper_pkg::SEL_TIMER_ZERO_COUNT;
					sfr_upper_pkg::IDX_PB_PINS: s = sfr_upper_pkg::SEL_PB;
					sfr_upper_pkg::IDX_NVD_LO:  s = sfr_upper_pkg::SEL_NVD;
					sfr_upper_pkg::IDX_NVA_LO:  s = sfr_upper_pkg::SEL_NVA;
					sfr_upper_pkg::IDX_NVD_HI:  s = sfr_upper_pkg::SEL_NVDH;
					sfr_upper_pkg::IDX_NVA_HI:  s = sfr_upper_pkg::SEL_NVAH;
					sfr_upper_pkg::IDX_OPTION:  s = sfr_upper_pkg::SEL_OPT;
					sfr_upper_pkg::IDX_PB_DIR:  s = sfr_upper_pkg::SEL_DIR;
					sfr_upper_pkg::IDX_NV_CTRL: s = sfr_upper_pkg::SEL_NVC;
					sfr_upper_pkg::IDX_UNLOCK:  s = sfr_upper_pkg::SEL_UNLOCK;
					sfr_upper_pkg::IDX_RSV_A:   s = sfr_upper_pkg::SEL_RSVA;
					sfr_upper_pkg::IDX_RSV_B:   s = sfr_upper_pkg::SEL_RSVB;
					// Absent port slots fall here and read zero
					default:                    s = sfr_upper_pkg::SEL_NONE;
				endcase
			end
		endcase
		return s;
	endfunction : decode

	// Reset pin, watchdog and port pins come from outside the clock domain
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			ext_sync_reg <= 2'h3;
			wdt_sync_reg <= 2'h0;
			pins_s1_reg  <= sfr_upper_pkg::RST_ZERO;
			pins_s2_reg  <= sfr_upper_pkg::RST_ZERO;
		end
		else
		begin
			ext_sync_reg <= {ext_sync_reg[0], EXT_RESET_PIN_N};
			wdt_sync_reg <= {wdt_sync_reg[0], WDT_TIMEOUT};
			pins_s1_reg  <= SECOND_PORT_PINS_PINS;
			pins_s2_reg  <= pins_s1_reg;
		end
	end

	assign other_rst = !ext_sync_reg[1] || wdt_sync_reg[1];

	assign wsel   = decode(aw_idx_reg);
	assign rsel   = decode(ar_idx_reg);
	assign wr_go  = (st_reg == sfr_upper_pkg::ST_IDLE) && aw_full_reg && w_full_reg;
	assign rd_go  = (st_reg == sfr_upper_pkg::ST_IDLE) && !wr_go && ar_full_reg;
	assign reg_wr = wr_go && wstrb_reg && (wsel != sfr_upper_pkg::SEL_IND);

	// Bus request capture
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			ar_full_reg <= 1'b0;
			aw_idx_reg  <= '0;
			ar_idx_reg  <= '0;
			wdata_reg   <= sfr_upper_pkg::RST_ZERO;
			wstrb_reg   <= 1'b0;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				aw_full_reg <= 1'b1;
				aw_idx_reg  <= AWADDR[sfr_upper_pkg::IDX_W+1:2];
			end
			else if (wr_go)
				aw_full_reg <= 1'b0;
			if (WVALID && WREADY)
			begin
				w_full_reg <= 1'b1;
				wdata_reg  <= WDATA[7:0];
				wstrb_reg  <= WSTRB[0];
			end
			else if (wr_go)
				w_full_reg <= 1'b0;
			if (ARVALID && ARREADY)
			begin
				ar_full_reg <= 1'b1;
				ar_idx_reg  <= ARADDR[sfr_upper_pkg::IDX_W+1:2];
			end
			else if (rd_go)
				ar_full_reg <= 1'b0;
		end
	end

	assign AWREADY = !aw_full_reg;
	assign WREADY  = !w_full_reg;
	assign ARREADY = !ar_full_reg;
	assign BVALID  = (st_reg == sfr_upper_pkg::ST_BRESP);
	assign RVALID  = (st_reg == sfr_upper_pkg::ST_RRESP);
	assign BRESP   = sfr_upper_pkg::RESP_OKAY;
	assign RRESP   = sfr_upper_pkg::RESP_OKAY;
	assign RDATA   = rdata_reg;

	// Read mux; unlisted locations and bits return zero
	always_comb
	begin
		unique case (rsel)
			sfr_upper_pkg::SEL_TIMER_ZERO_COUNT:   rbyte = timer_zero_count_reg;
			sfr_upper_pkg::SEL_PCL:    rbyte = pc_reg[7:0];
			sfr_upper_pkg::SEL_ALU:    rbyte = alu_reg;
			sfr_upper_pkg::SEL_PTR:    rbyte = ptr_reg;
			sfr_upper_pkg::SEL_PB:     rbyte = pins_s2_reg;
			sfr_upper_pkg::SEL_PCH:    rbyte = {3'h0, pch_reg};
			sfr_upper_pkg::SEL_IRQ:    rbyte = irq_reg;
			sfr_upper_pkg::SEL_NVD:    rbyte = nvd_reg;
			sfr_upper_pkg::SEL_NVA:    rbyte = nva_reg;
			sfr_upper_pkg::SEL_NVDH:   rbyte = nvdh_reg;
			sfr_upper_pkg::SEL_NVAH:   rbyte = nvah_reg;
			sfr_upper_pkg::SEL_OPT:    rbyte = opt_reg;
			sfr_upper_pkg::SEL_DIR:    rbyte = dir_reg;
			sfr_upper_pkg::SEL_NVC:    rbyte = nvc_reg;
			sfr_upper_pkg::SEL_RSVA:   rbyte = rsva_reg;
			sfr_upper_pkg::SEL_RSVB:   rbyte = rsvb_reg;
			default:                   rbyte = sfr_upper_pkg::RST_ZERO;
		endcase
	end

	// Transaction sequencer and indirect memory port
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			st_reg    <= sfr_upper_pkg::ST_IDLE;
			dm_reg    <= '0;
			rdata_reg <= '0;
		end
		else
		begin
			unique case (st_reg)
				sfr_upper_pkg::ST_IDLE:
				begin
					if (wr_go && wsel == sfr_upper_pkg::SEL_IND && wstrb_reg)
					begin
						dm_reg <= '{1'b1, 1'b1, {alu_reg.irp, ptr_reg}, wdata_reg};
						st_reg <= sfr_upper_pkg::ST_MEM_WR;
					end
					else if (wr_go)
						st_reg <= sfr_upper_pkg::ST_BRESP;
					else if (rd_go && rsel == sfr_upper_pkg::SEL_IND)
					begin
						dm_reg <= '{1'b1, 1'b0, {alu_reg.irp, ptr_reg}, 8'h00};
						st_reg <= sfr_upper_pkg::ST_MEM_RD;
					end
					else if (rd_go)
					begin
						rdata_reg <= {24'h0, rbyte};
						st_reg    <= sfr_upper_pkg::ST_RRESP;
					end
				end
				sfr_upper_pkg::ST_MEM_WR:
				begin
					if (DM_ACK)
					begin
						dm_reg.valid <= 1'b0;
						st_reg       <= sfr_upper_pkg::ST_BRESP;
					end
				end
				sfr_upper_pkg::ST_MEM_RD:
				begin
					if (DM_ACK)
					begin
						dm_reg.valid <= 1'b0;
						rdata_reg    <= {24'h0, DM_RDATA};
						st_reg       <= sfr_upper_pkg::ST_RRESP;
					end
				end
				sfr_upper_pkg::ST_BRESP:
				begin
					if (BREADY)
						st_reg <= sfr_upper_pkg::ST_IDLE;
				end
				sfr_upper_pkg::ST_RRESP:
				begin
					if (RREADY)
						st_reg <= sfr_upper_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Program counter and its high latch
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			pc_reg  <= '0;
			pch_reg <= '0;
		end
		else if (other_rst)
		begin
			pc_reg  <= '0;
			pch_reg <= '0;
		end
		else
		begin
			if (reg_wr && wsel == sfr_upper_pkg::SEL_PCH)
				pch_reg <= wdata_reg[4:0];
			if (reg_wr && wsel == sfr_upper_pkg::SEL_PCL)
				pc_reg <= {pch_reg, wdata_reg};
			else if (BRANCH_TAKE)
				pc_reg <= {pch_reg[4:3], BRANCH_TARGET};
			else if (PC_ADVANCE)
				pc_reg <= pc_reg + 13'h1;
		end
	end

	// Arithmetic status; hardware flag updates override a software write
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			alu_reg <= sfr_upper_pkg::RST_ALU_POR;
		else if (other_rst)
		begin
			alu_reg.irp         <= 1'b0;
			alu_reg.bank_sel    <= 2'h0;
			alu_reg.not_timeout <= !wdt_sync_reg[1];
		end
		else
		begin
			if (reg_wr && wsel == sfr_upper_pkg::SEL_ALU)
			begin
				alu_reg.irp         <= wdata_reg[7];
				alu_reg.bank_sel    <= wdata_reg[6:5];
				alu_reg.zero        <= wdata_reg[2];
				alu_reg.digit_carry <= wdata_reg[1];
				alu_reg.carry       <= wdata_reg[0];
			end
			if (ALU_FLAG_UPDATE)
				{alu_reg.zero, alu_reg.digit_carry, alu_reg.carry} <= ALU_FLAG_VALUE;
			if (SLEEP_ENTER)
				{alu_reg.not_timeout, alu_reg.not_powerdown} <= 2'h2;
			if (WDT_CLEAR)
				{alu_reg.not_timeout, alu_reg.not_powerdown} <= 2'h3;
		end
	end

	// Interrupt control; an event in the write cycle still sets its flag
	always_comb
	begin
		irq_next = irq_reg;
		if (reg_wr && wsel == sfr_upper_pkg::SEL_IRQ)
			irq_next = wdata_reg;
		irq_next.t0if = irq_next.t0if | IRQ_EVENTS[2];
		irq_next.intf = irq_next.intf | IRQ_EVENTS[1];
		irq_next.rbif = irq_next.rbif | IRQ_EVENTS[0];
	end

	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			irq_reg <= sfr_upper_pkg::RST_ZERO;
		else if (other_rst)
			irq_reg <= {7'h00, irq_reg.rbif};
		else
			irq_reg <= irq_next;
	end

	// Nonvolatile control; go bits set by software, cleared on completion
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
			nvc_reg <= sfr_upper_pkg::RST_ZERO;
		else if (other_rst)
		begin
			nvc_reg.wr_err <= nvc_reg.wr_err | nvc_reg.wr_go;
			nvc_reg.wr_en  <= 1'b0;
			nvc_reg.wr_go  <= 1'b0;
			nvc_reg.rd_go  <= 1'b0;
		end
		else if (reg_wr && wsel == sfr_upper_pkg::SEL_NVC)
		begin
			nvc_reg.prog_space <= wdata_reg[7];
			nvc_reg.wr_err     <= wdata_reg[3];
			nvc_reg.wr_en      <= wdata_reg[2];
			nvc_reg.wr_go      <= nvc_reg.wr_go | (wdata_reg[1] & nvc_reg.wr_en);
			nvc_reg.rd_go      <= nvc_reg.rd_go | wdata_reg[0];
		end
		else if (NV_DONE)
		begin
			nvc_reg.wr_go <= 1'b0;
			nvc_reg.rd_go <= 1'b0;
		end
	end

	// Unlock port: strobe only, nothing is kept for reads
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			unl_stb_reg <= 1'b0;
			unl_dat_reg <= sfr_upper_pkg::RST_ZERO;
		end
		else
		begin
			unl_stb_reg <= reg_wr && wsel == sfr_upper_pkg::SEL_UNLOCK;
			if (reg_wr && wsel == sfr_upper_pkg::SEL_UNLOCK)
				unl_dat_reg <= wdata_reg;
		end
	end

	// Data registers that hold their contents over a non-power-up reset
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			timer_zero_count_reg  <= sfr_upper_pkg::RST_ZERO;
			ptr_reg   <= sfr_upper_pkg::RST_ZERO;
			latch_reg <= sfr_upper_pkg::RST_ZERO;
			nvd_reg   <= sfr_upper_pkg::RST_ZERO;
			nva_reg   <= sfr_upper_pkg::RST_ZERO;
			nvdh_reg  <= sfr_upper_pkg::RST_ZERO;
			nvah_reg  <= sfr_upper_pkg::RST_ZERO;
		end
		else if (reg_wr && !other_rst)
		begin
			unique case (wsel)
				sfr_upper_pkg::SEL_TIMER_ZERO_COUNT: timer_zero_count_reg  <= wdata_reg;
				sfr_upper_pkg::SEL_PTR:  ptr_reg   <= wdata_reg;
				sfr_upper_pkg::SEL_PB:   latch_reg <= wdata_reg;
				sfr_upper_pkg::SEL_NVD:  nvd_reg   <= wdata_reg;
				sfr_upper_pkg::SEL_NVA:  nva_reg   <= wdata_reg;
				sfr_upper_pkg::SEL_NVDH: nvdh_reg  <= wdata_reg & sfr_upper_pkg::MASK_NVD_HI;
				sfr_upper_pkg::SEL_NVAH: nvah_reg  <= wdata_reg & sfr_upper_pkg::MASK_NVA_HI;
				default:                 timer_zero_count_reg  <= timer_zero_count_reg;
			endcase
		end
	end

	// Registers with one reset value for every cause
	always_ff @(posedge MCLK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			opt_reg  <= sfr_upper_pkg::RST_ONES;
			dir_reg  <= sfr_upper_pkg::RST_ONES;
			rsva_reg <= sfr_upper_pkg::RST_ZERO;
			rsvb_reg <= sfr_upper_pkg::RST_ZERO;
		end
		else if (other_rst)
		begin
			opt_reg  <= sfr_upper_pkg::RST_ONES;
			dir_reg  <= sfr_upper_pkg::RST_ONES;
			rsva_reg <= sfr_upper_pkg::RST_ZERO;
			rsvb_reg <= sfr_upper_pkg::RST_ZERO;
		end
		else if (reg_wr)
		begin
			unique case (wsel)
				sfr_upper_pkg::SEL_OPT:  opt_reg  <= wdata_reg;
				sfr_upper_pkg::SEL_DIR:  dir_reg  <= wdata_reg;
				sfr_upper_pkg::SEL_RSVA: rsva_reg <= wdata_reg;
				sfr_upper_pkg::SEL_RSVB: rsvb_reg <= wdata_reg;
				default:                 opt_reg  <= opt_reg;
			endcase
		end
	end

	assign DM_REQ           = dm_reg;
	assign PC_VALUE         = pc_reg;
	assign ALU_FLAGS        = alu_reg;
	assign IRQ_CONTROL      = irq_reg;
	assign NV_CONTROL       = nvc_reg & sfr_upper_pkg::MASK_NV_CTRL;
	assign NV_ADDR          = {nvah_reg, nva_reg};
	assign NV_DATA          = {nvdh_reg, nvd_reg};
	assign NV_UNLOCK_STROBE = unl_stb_reg;
	assign NV_UNLOCK_DATA   = unl_dat_reg;
	assign OPTION_BITS      = opt_reg;
	assign TIMER_ZERO       = timer_zero_count_reg;
	assign SECOND_PORT_PINS_LATCH      = latch_reg;
	assign SECOND_PORT_PINS_DIR        = dir_reg;
endmodule : sfr_upper_banks

// >>> tb/sfr_dm_model.sv
`timescale 1ns/100ps
module sfr_dm_model (
	input  wire logic                   MCLK,
	input  wire logic                   RESET_N,
	input  wire sfr_upper_pkg::dm_req_t DM_REQ,
	output      logic [7:0]             DM_RDATA,
	output      logic                   DM_ACK
);
	logic [7:0] mem [512];
	logic [1:0] wait_reg;
	logic       slow_reg;
	// Alternates prompt and slow answers; data garbled outside answers
	always_ff @(posedge MCLK or negedge RESET_N)
		if (!RESET_N)
		begin
			DM_ACK <= 1'b0;
			DM_RDATA <= 8'h00;
			wait_reg <= 2'h0;
			slow_reg <= 1'b0;
		end
		else
		begin
			DM_ACK <= 1'b0;
			DM_RDATA <= ~DM_RDATA;
			if (DM_REQ.valid && !DM_ACK && wait_reg != {2{slow_reg}})
				wait_reg <= wait_reg + 2'h1;
			else if (DM_REQ.valid && !DM_ACK)
			begin
				DM_ACK <= 1'b1;
				wait_reg <= 2'h0;
				slow_reg <= !slow_reg;
				DM_RDATA <= mem[DM_REQ.addr];
				if (DM_REQ.we)
					mem[DM_REQ.addr] <= DM_REQ.wdata;
			end
		end
endmodule : sfr_dm_model

// >>> tb/sfr_upper_chk.sv
`timescale 1ns/100ps
module sfr_upper_chk #(
	parameter int ADDR_W = 11
) (
	input wire logic                   MCLK,
	input wire logic                   RESET_N,
	input wire logic                   EXT_RESET_PIN_N,
	input wire logic                   WDT_TIMEOUT,
	input wire logic                   AWVALID,
	input wire logic                   AWREADY,
	input wire logic                   WVALID,
	input wire logic                   WREADY,
	input wire logic [1:0]             BRESP,
	input wire logic                   BVALID,
	input wire logic [ADDR_W-1:0]      ARADDR,
	input wire logic                   ARVALID,
	input wire logic                   ARREADY,
	input wire logic [31:0]            RDATA,
	input wire logic                   RVALID,
	input wire logic                   PC_ADVANCE,
	input wire logic                   BRANCH_TAKE,
	input wire logic [10:0]            BRANCH_TARGET,
	input wire logic                   DM_ACK,
	input wire sfr_upper_pkg::dm_req_t DM_REQ,
	input wire logic [12:0]            PC_VALUE,
	input wire logic                   NV_UNLOCK_STROBE,
	input wire logic [7:0]             OPTION_BITS
);
	logic [1:0] quiet_reg;
	logic       idle;
	// No write taken or pending in this cycle
	assign idle = AWREADY && WREADY && !AWVALID && !WVALID;
	always_ff @(posedge MCLK or negedge RESET_N)
		if (!RESET_N)
			quiet_reg <= 2'h0;
		else if (!EXT_RESET_PIN_N || WDT_TIMEOUT)
			quiet_reg <= 2'h0;
		else if (quiet_reg != 2'h3)
			quiet_reg <= quiet_reg + 2'h1;
	default clocking dc @(posedge MCLK);
	endclocking
	default disable iff (!RESET_N);
	a_rdata_upper: assert property (RVALID |-> RDATA[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_bresp_okay: assert property (BVALID |-> BRESP == 2'h0)
		else $error("write response not okay");
	a_read_answer: assert property (ARVALID && ARREADY && ARADDR[8:2] != 7'h0 && idle
		|-> ##2 RVALID) else $error("register read not answered");
	a_pc_step: assert property (PC_ADVANCE && !BRANCH_TAKE && idle && quiet_reg == 2'h3
		|=> PC_VALUE == $past(PC_VALUE) + 13'h1) else $error("counter did not step");
	a_branch_load: assert property (BRANCH_TAKE && idle && quiet_reg == 2'h3
		|=> PC_VALUE[10:0] == $past(BRANCH_TARGET)) else $error("branch not loaded");
	a_other_reset: assert property (WDT_TIMEOUT [*4]
		|-> PC_VALUE == 13'h0 && OPTION_BITS == 8'hff) else $error("other reset values wrong");
	a_strobe_single: assert property (NV_UNLOCK_STROBE |=> !NV_UNLOCK_STROBE)
		else $error("unlock strobe too long");
	a_dm_hold: assert property (DM_REQ.valid && !DM_ACK |=> $stable(DM_REQ))
		else $error("memory request dropped");
	a_dm_answer: assert property (DM_REQ.valid && DM_ACK |-> ##[1:2] (BVALID || RVALID))
		else $error("indirect access not answered");
endmodule : sfr_upper_chk
bind sfr_upper_banks sfr_upper_chk #(.ADDR_W(ADDR_W)) i_sfr_upper_chk (.MCLK, .RESET_N,
	.EXT_RESET_PIN_N, .WDT_TIMEOUT, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID,
	.ARADDR, .ARVALID, .ARREADY, .RDATA, .RVALID, .PC_ADVANCE, .BRANCH_TAKE, .BRANCH_TARGET,
	.DM_ACK, .DM_REQ, .PC_VALUE, .NV_UNLOCK_STROBE, .OPTION_BITS);

// >>> tb/sfr_upper_banks_tb.sv
`timescale 1ns/100ps
module sfr_upper_banks_tb;
	logic                   MCLK = 1'b0, RESET_N = 1'b0, EXT_RESET_PIN_N = 1'b1;
	logic                   WDT_TIMEOUT = 1'b0, AWVALID = 1'b0, WVALID = 1'b0;
	logic                   BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0, PC_ADVANCE = 1'b0;
	logic                   BRANCH_TAKE = 1'b0, ALU_FLAG_UPDATE = 1'b0;
	logic [10:0]            AWADDR = 11'h0, ARADDR = 11'h0, BRANCH_TARGET = 11'h0;
	logic [31:0]            WDATA = 32'h0;
	logic [3:0]             WSTRB = 4'h0;
	logic [2:0]             ALU_FLAG_VALUE = 3'h0;
	logic                   AWREADY, WREADY, BVALID, ARREADY, RVALID, DM_ACK, NV_UNLOCK_STROBE;
	logic [1:0]             BRESP, RRESP;
	logic [31:0]            RDATA;
	logic [12:0]            PC_VALUE;
	logic [7:0]             DM_RDATA, NV_UNLOCK_DATA, strobe_data;
	sfr_upper_pkg::dm_req_t DM_REQ;
	int                     fail_count = 0, n_tests = 0, n_strobe = 0;
	sfr_upper_banks i_sfr_upper_banks (.MCLK, .RESET_N, .EXT_RESET_PIN_N, .WDT_TIMEOUT, .AWADDR,
		.AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
		.ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .PC_ADVANCE, .BRANCH_TAKE,
		.BRANCH_TARGET, .ALU_FLAG_UPDATE, .ALU_FLAG_VALUE, .SLEEP_ENTER(1'b0), .WDT_CLEAR(1'b0),
		.IRQ_EVENTS(3'h0), .NV_DONE(1'b0), .SECOND_PORT_PINS_PINS(8'ha5), .DM_RDATA, .DM_ACK, .DM_REQ,
		.PC_VALUE, .ALU_FLAGS(), .IRQ_CONTROL(), .NV_CONTROL(), .NV_ADDR(), .NV_DATA(),
		.NV_UNLOCK_STROBE, .NV_UNLOCK_DATA, .OPTION_BITS(), .TIMER_ZERO(), .SECOND_PORT_PINS_LATCH(),
		.SECOND_PORT_PINS_DIR());
	sfr_dm_model i_sfr_dm_model (.MCLK, .RESET_N, .DM_REQ, .DM_RDATA, .DM_ACK);
	always #5 MCLK = ~MCLK;
	always @(posedge MCLK)
		if (NV_UNLOCK_STROBE === 1'b1)
		begin
			n_strobe++;
			strobe_data = NV_UNLOCK_DATA;
		end
	task end_sim;
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_sim
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			fail_count++;
		end
	endtask : chk
	task tmo(input logic ok);
		if (!ok)
		begin
			fail_count++;
			end_sim();
		end
	endtask : tmo
	task wr(input logic [8:0] i, input logic [7:0] d);
		logic aw, w, b, done;
		done = 1'b0;
		@(posedge MCLK);
		AWADDR <= {i, 2'b00};
		WDATA <= {24'h0, d};
		WSTRB <= 4'h1;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (int n = 0; n < 200 && !done; n++)
		begin
			@(negedge MCLK);
			aw = AWREADY;
			w = WREADY;
			b = BVALID;
			@(posedge MCLK);
			if (aw === 1'b1)
				AWVALID <= 1'b0;
			if (w === 1'b1)
				WVALID <= 1'b0;
			if (b === 1'b1)
				BREADY <= 1'b0;
			done = (b === 1'b1);
		end
		tmo(done);
	endtask : wr
	task rc(input logic [8:0] i, input logic [7:0] e);
		logic ar, done;
		logic [31:0] d;
		done = 1'b0;
		@(posedge MCLK);
		ARADDR <= {i, 2'b00};
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (int n = 0; n < 200 && !done; n++)
		begin
			@(negedge MCLK);
			ar = ARREADY;
			done = (RVALID === 1'b1);
			d = RDATA;
			@(posedge MCLK);
			if (ar === 1'b1)
				ARVALID <= 1'b0;
			if (done)
				RREADY <= 1'b0;
		end
		tmo(done);
		chk(d, {24'h0, e});
	endtask : rc
	task pulse(input logic [1:0] k);
		@(posedge MCLK);
		{BRANCH_TAKE, PC_ADVANCE} <= k;
		@(posedge MCLK);
		{BRANCH_TAKE, PC_ADVANCE} <= 2'b00;
		@(negedge MCLK);
	endtask : pulse
	task t_reset_vals;
		rc(9'h181, 8'hff);
		rc(9'h186, 8'hff);
		rc(9'h103, 8'h18);
		rc(9'h10a, 8'h00);
		rc(9'h18e, 8'h00);
		rc(9'h18f, 8'h00);
	endtask : t_reset_vals
	task t_mirror;
		wr(9'h10a, 8'hff);
		rc(9'h18a, 8'h1f);
		rc(9'h00a, 8'h1f);
		wr(9'h184, 8'h66);
		rc(9'h104, 8'h66);
		wr(9'h18b, 8'h80);
		rc(9'h10b, 8'h80);
	endtask : t_mirror
	task t_unmapped;
		logic [8:0] u [8];
		u = '{9'h105, 9'h107, 9'h108, 9'h109, 9'h185, 9'h187, 9'h188, 9'h189};
		foreach (u[k])
		begin
			wr(u[k], 8'haa);
			rc(u[k], 8'h00);
		end
	endtask : t_unmapped
	task t_pc;
		wr(9'h102, 8'h34);
		@(negedge MCLK);
		chk({19'h0, PC_VALUE}, 32'h1f34);
		@(posedge MCLK);
		BRANCH_TARGET <= 11'h123;
		pulse(2'b10);
		chk({19'h0, PC_VALUE}, 32'h1923);
		pulse(2'b01);
		pulse(2'b01);
		rc(9'h182, 8'h25);
	endtask : t_pc
	task t_indirect;
		wr(9'h104, 8'h40);
		wr(9'h100, 8'h5a);
		wr(9'h184, 8'h41);
		wr(9'h180, 8'hc3);
		rc(9'h080, 8'hc3);
		wr(9'h004, 8'h40);
		rc(9'h180, 8'h5a);
	endtask : t_indirect
	task t_unlock;
		wr(9'h18d, 8'h3c);
		@(negedge MCLK);
		chk(n_strobe, 32'h1);
		chk({24'h0, strobe_data}, 32'h3c);
		rc(9'h18d, 8'h00);
	endtask : t_unlock
	task t_other_reset;
		wr(9'h104, 8'h55);
		wr(9'h181, 8'h00);
		wr(9'h18e, 8'h77);
		@(posedge MCLK);
		ALU_FLAG_UPDATE <= 1'b1;
		ALU_FLAG_VALUE <= 3'b101;
		@(posedge MCLK);
		ALU_FLAG_UPDATE <= 1'b0;
		WDT_TIMEOUT <= 1'b1;
		repeat (5) @(posedge MCLK);
		WDT_TIMEOUT <= 1'b0;
		repeat (4) @(posedge MCLK);
		rc(9'h181, 8'hff);
		rc(9'h10a, 8'h00);
		rc(9'h18e, 8'h00);
		rc(9'h104, 8'h55);
		rc(9'h103, 8'h0d);
		EXT_RESET_PIN_N <= 1'b0;
		repeat (5) @(posedge MCLK);
		EXT_RESET_PIN_N <= 1'b1;
		repeat (4) @(posedge MCLK);
		rc(9'h103, 8'h1d);
	endtask : t_other_reset
	initial
	begin
		repeat (12) @(posedge MCLK);
		RESET_N <= 1'b1;
		t_reset_vals();
		t_mirror();
		t_unmapped();
		t_pc();
		t_indirect();
		t_unlock();
		t_other_reset();
		end_sim();
	end
endmodule : sfr_upper_banks_tb
